// ### acso_channel.sv
// Audio channel sample output: APB registers, DMA fetch, direct writes, DAC feed
`timescale 1ns/1ns

// Operation
// RQ1: single buffer repeats by automatic pointer reload
// RQ2: DMA mode interrupts after data address read
// RQ3: direct mode interrupts per word sent
// RQ4: late direct data holds last sample
// RQ5: processor writes one word at a time
// RQ6: volume and period used in both modes
// RQ7: sample bytes are signed eight-bit values
// RQ8: filter bypass shares the power LED bit
// RQ9: length zero reloads location and length
// RQ10: period counter paces each sample
module acso_channel
  import acso_pkg::*;
#(
  parameter int AW = 24
) (
  // Clock and reset
  input  wire logic               SYS_CLK_I,
  input  wire logic               SYS_RST_I,
  // APB slave
  input  wire logic               APB_PSEL_I,
  input  wire logic               APB_PENABLE_I,
  input  wire logic               APB_PWRITE_I,
  input  wire logic [7:0]         APB_PADDR_I,
  input  wire logic [31:0]        APB_PWDATA_I,
  output logic      [31:0]        APB_PRDATA_O,
  output logic                    APB_PREADY_O,
  output logic                    APB_PSLVERR_O,
  // Sample fetch from memory
  output logic                    DMA_REQ_O,
  output logic      [AW-1:0]      DMA_ADDR_O,
  input  wire logic               DMA_ACK_I,
  input  wire logic [15:0]        DMA_DATA_I,
  // Converter feed
  output logic signed [7:0]       DAC_SAMPLE_O,
  output logic      [6:0]         DAC_VOLUME_O,
  output logic signed [15:0]      DAC_LEVEL_O,
  // Filter bypass, shared with the power LED brightness
  output logic                    FILTER_LED_O,
  // Interrupt
  output logic                    IRQ_O
);

  // Bus phase decode
  logic setup;
  logic acc_wr;
  logic acc_rd;
  assign setup  = APB_PSEL_I && !APB_PENABLE_I;
  assign acc_wr = APB_PSEL_I && APB_PENABLE_I && APB_PWRITE_I;
  assign acc_rd = APB_PSEL_I && APB_PENABLE_I && !APB_PWRITE_I;

  // Register state
  logic [1:0]          ctrl_q, ctrl_d;
  logic [AW-1:0]       loc_q, loc_d;
  logic [15:0]         len_q, len_d;
  logic [15:0]         per_q, per_d;
  logic [6:0]          vol_q, vol_d;
  logic [ACSO_NEV-1:0] stat_q, stat_d;
  logic [ACSO_NEV-1:0] mask_q, mask_d;
  logic [31:0]         prdata_q, prdata_d;
  logic                slverr_q, slverr_d;

  // Channel state
  logic [AW-1:0]       wptr_q, wptr_d;
  logic [15:0]         wlen_q, wlen_d;
  logic [15:0]         pend_q, pend_d;
  logic                pend_full_q, pend_full_d;
  logic [15:0]         word_q, word_d;
  acso_play_type       play_q, play_d;
  logic [7:0]          sample_q, sample_d;
  logic signed [15:0]  level_q, level_d;
  logic [1:0]          idle_q, idle_d;
  logic                req_q, req_d;
  logic                dma_on_q, dma_on_d;
  logic [ACSO_NEV-1:0] ev;

  logic dma_en;
  logic start;
  assign dma_en = ctrl_q[ACSO_CTRL_DMA];
  assign start  = dma_en && !dma_on_q;

  // Sampling period timer
  acso_tick_if tif ();
  assign tif.period = per_q; // RQ6
  assign tif.run    = dma_en || (play_q != PS_EMPTY) || pend_full_q || (idle_q != ACSO_STARVE_TICKS);

  acso_period_timer u_timer (
    .clk_i (SYS_CLK_I),
    .rst_i (SYS_RST_I),
    .tif   (tif)
  );

  // Register file next state; reads are captured in setup, so access has no wait
  always_comb begin
    ctrl_d   = ctrl_q;
    loc_d    = loc_q;
    len_d    = len_q;
    per_d    = per_q;
    vol_d    = vol_q;
    mask_d   = mask_q;
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    if (setup) begin
      slverr_d = 1'b0;
      case (APB_PADDR_I)
        ACSO_CTRL_OFS: begin
          prdata_d = {30'h0, ctrl_q};
        end
        ACSO_LOC_OFS: begin
          prdata_d = 32'(loc_q);
        end
        ACSO_LEN_OFS: begin
          prdata_d = {16'h0, len_q};
        end
        ACSO_PER_OFS: begin
          prdata_d = {16'h0, per_q};
        end
        ACSO_VOL_OFS: begin
          prdata_d = {25'h0, vol_q};
        end
        ACSO_DAT_OFS: begin
          prdata_d = {16'h0, pend_q};
        end
        ACSO_STAT_OFS: begin
          prdata_d = {29'h0, stat_q};
        end
        ACSO_MASK_OFS: begin
          prdata_d = {29'h0, mask_q};
        end
        ACSO_STATE_OFS: begin
          prdata_d = {21'h0, req_q, (play_q == PS_LOW_NEXT), pend_full_q, sample_q};
        end
        default: begin
          prdata_d = 32'h0;
          slverr_d = 1'b1;
        end
      endcase
    end
    if (acc_wr) begin
      case (APB_PADDR_I)
        ACSO_CTRL_OFS: ctrl_d = APB_PWDATA_I[1:0]; // RQ8
        ACSO_LOC_OFS:  loc_d  = APB_PWDATA_I[AW-1:0];
        ACSO_LEN_OFS:  len_d  = APB_PWDATA_I[15:0];
        ACSO_PER_OFS:  per_d  = APB_PWDATA_I[15:0];
        ACSO_VOL_OFS:  vol_d  = APB_PWDATA_I[6:0];
        ACSO_MASK_OFS: mask_d = APB_PWDATA_I[ACSO_NEV-1:0];
        default:       ctrl_d = ctrl_q;
      endcase
    end
    // Only bits already shown to the reader are cleared; a new event wins
    stat_d = stat_q;
    if (acc_rd && APB_PADDR_I == ACSO_STAT_OFS) begin
      stat_d = stat_q & ~prdata_q[ACSO_NEV-1:0];
    end
    stat_d = stat_d | ev;
  end

  // Register file flops
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_q   <= ACSO_CTRL_RST;
      loc_q    <= '0;
      len_q    <= ACSO_LEN_RST;
      per_q    <= ACSO_PER_RST;
      vol_q    <= ACSO_VOL_RST;
      stat_q   <= '0;
      mask_q   <= '0;
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      loc_q    <= loc_d;
      len_q    <= len_d;
      per_q    <= per_d;
      vol_q    <= vol_d;
      stat_q   <= stat_d;
      mask_q   <= mask_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  // Sample path next state: consume on ticks first, then refill from DMA or a write
  always_comb begin
    wptr_d      = wptr_q;
    wlen_d      = wlen_q;
    pend_d      = pend_q;
    pend_full_d = pend_full_q;
    word_d      = word_q;
    play_d      = play_q;
    sample_d    = sample_q;
    idle_d      = idle_q;
    dma_on_d    = dma_en;
    ev          = '0;
    if (tif.tick) begin
      case (play_q)
        PS_LOW_NEXT: begin
          sample_d = word_q[7:0];
          play_d   = PS_EMPTY;
          idle_d   = 2'h0;
          if (!dma_en) begin
            ev[ACSO_EV_WORD] = 1'b1; // RQ3
          end
        end
        PS_EMPTY: begin
          if (pend_full_q) begin
            word_d      = pend_q;
            sample_d    = pend_q[15:8];
            play_d      = PS_LOW_NEXT;
            pend_full_d = 1'b0;
            idle_d      = 2'h0;
          end else if (idle_q != ACSO_STARVE_TICKS) begin
            // Nothing new: the converter keeps the last byte
            idle_d = idle_q + 2'h1; // RQ4
            if (idle_d == ACSO_STARVE_TICKS && !dma_en) begin
              ev[ACSO_EV_STARVE] = 1'b1; // RQ4
            end
          end
        end
        default: begin
          play_d = PS_EMPTY;
        end
      endcase
    end
    if (start) begin
      // Working copies taken, software may now rewrite location and length
      wptr_d             = loc_q;
      wlen_d             = len_q;
      ev[ACSO_EV_ADDR]   = 1'b1; // RQ2
    end else if (req_q && DMA_ACK_I) begin
      pend_d      = DMA_DATA_I;
      pend_full_d = 1'b1;
      if (wlen_q <= 16'h0001) begin
        // Buffer end: restart from the programmed pointers
        wptr_d           = loc_q; // RQ1 RQ9
        wlen_d           = len_q; // RQ9
        ev[ACSO_EV_ADDR] = 1'b1; // RQ2
      end else begin
        wptr_d = wptr_q + AW'(2);
        wlen_d = wlen_q - 16'h0001;
      end
    end
    // Direct mode: each data write supplies one word; ignored while DMA owns the channel
    if (acc_wr && APB_PADDR_I == ACSO_DAT_OFS && !dma_en) begin
      pend_d      = APB_PWDATA_I[15:0]; // RQ5
      pend_full_d = 1'b1;
    end
    // Request stays up, address steady, until the word is taken
    req_d   = dma_en && !pend_full_d;
    // Bytes are two's complement; the product with volume keeps the sign
    level_d = $signed(sample_q) * $signed({1'b0, vol_q}); // RQ6 RQ7
  end

  // Sample path flops
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      wptr_q      <= '0;
      wlen_q      <= ACSO_LEN_RST;
      pend_q      <= 16'h0000;
      pend_full_q <= 1'b0;
      word_q      <= 16'h0000;
      play_q      <= PS_EMPTY;
      sample_q    <= 8'h00;
      level_q     <= 16'sh0000;
      idle_q      <= ACSO_STARVE_TICKS;
      req_q       <= 1'b0;
      dma_on_q    <= 1'b0;
    end else begin
      wptr_q      <= wptr_d;
      wlen_q      <= wlen_d;
      pend_q      <= pend_d;
      pend_full_q <= pend_full_d;
      word_q      <= word_d;
      play_q      <= play_d;
      sample_q    <= sample_d;
      level_q     <= level_d;
      idle_q      <= idle_d;
      req_q       <= req_d;
      dma_on_q    <= dma_on_d;
    end
  end

  // Outputs
  assign APB_PRDATA_O  = prdata_q;
  assign APB_PREADY_O  = APB_PSEL_I && APB_PENABLE_I;
  assign APB_PSLVERR_O = APB_PSEL_I && APB_PENABLE_I && slverr_q;
  assign DMA_REQ_O     = req_q;
  assign DMA_ADDR_O    = wptr_q;
  assign DAC_SAMPLE_O  = $signed(sample_q); // RQ7
  assign DAC_VOLUME_O  = vol_q; // RQ6
  assign DAC_LEVEL_O   = level_q;
  assign FILTER_LED_O  = ctrl_q[ACSO_CTRL_FILT]; // RQ8
  assign IRQ_O         = |(stat_q & mask_q);

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  chk_buffer_reload: assert property ((req_q && DMA_ACK_I && !start && wlen_q == 16'h0001) // RQ1
    |=> (wptr_q == $past(loc_q) && wlen_q == $past(len_q)))
    else $error("pointers not reloaded at buffer end");

  chk_walk_pointer: assert property ((req_q && DMA_ACK_I && !start && wlen_q > 16'h0001) // RQ9
    |=> (wptr_q == $past(wptr_q) + AW'(2) && wlen_q == $past(wlen_q) - 16'h0001))
    else $error("working pointers did not advance by one word");

  chk_addr_irq: assert property ($rose(dma_en) |-> ##1 stat_q[ACSO_EV_ADDR]) // RQ2
    else $error("address read did not flag the interrupt");

  chk_word_irq: assert property ((tif.tick && play_q == PS_LOW_NEXT && !dma_en) // RQ3
    |=> stat_q[ACSO_EV_WORD] && play_q == PS_EMPTY)
    else $error("word sent without interrupt flag");

  chk_hold_sample: assert property ((play_q == PS_EMPTY && !pend_full_q) |=> $stable(sample_q)) // RQ4
    else $error("sample changed with no new data");

  chk_starve_flag: assert property ((tif.tick && play_q == PS_EMPTY && !pend_full_q && !dma_en // RQ4
    && idle_q == 2'h1) |=> stat_q[ACSO_EV_STARVE])
    else $error("two empty intervals not flagged");

  chk_level_scale: assert property (##1 (level_q == $past(16'($signed(sample_q) * $signed({1'b0, vol_q}))))) // RQ6
    else $error("volume not applied to sample");

  chk_signed_byte: assert property ((tif.tick && play_q == PS_EMPTY && pend_full_q) // RQ7
    |=> DAC_SAMPLE_O == $signed($past(pend_q[15:8]))
      ##1 (DAC_LEVEL_O[15] == ($past(DAC_SAMPLE_O[7]) && $past(vol_q) != 7'h00)))
    else $error("high byte not presented as signed sample");

  chk_filter_led: assert property ((acc_wr && APB_PADDR_I == ACSO_CTRL_OFS) // RQ8
    |=> FILTER_LED_O == $past(APB_PWDATA_I[ACSO_CTRL_FILT]))
    else $error("filter and LED bit not taken from control write");

  cov_dma_wrap: cover property (req_q && DMA_ACK_I && wlen_q == 16'h0001);
  cov_direct_word: cover property (tif.tick && play_q == PS_LOW_NEXT && !dma_en);
  cov_starved: cover property (ev[ACSO_EV_STARVE]);
  cov_irq_read: cover property (IRQ_O ##[1:20] !IRQ_O);

endmodule

// ### acso_mem_model.sv
// Memory model answering the channel's sample fetch requests
`timescale 1ns/1ns
module acso_mem_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Fetch request from the channel, answer latency from the bench
  input  wire logic        dma_req_i,
  input  wire logic [23:0] dma_addr_i,
  input  wire logic [3:0]  lat_i,
  // Answer to the channel
  output logic             dma_ack_o,
  output logic      [15:0] dma_data_o
);
  logic [3:0]  wait_q;
  logic [15:0] last_q;

  // Answer after lat_i idle cycles; word is a pattern of its own address.
  // Outside an answer the data bus shows the inverse of the last word,
  // so a design that samples without the ack sees garbage, not luck.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dma_ack_o  <= 1'b0;
      dma_data_o <= 16'h0000;
      wait_q     <= 4'h0;
      last_q     <= 16'h0000;
    end else begin
      dma_ack_o  <= 1'b0;
      dma_data_o <= ~last_q;
      if (dma_req_i && !dma_ack_o) begin
        if (wait_q == lat_i) begin
          dma_ack_o  <= 1'b1;
          dma_data_o <= {dma_addr_i[7:0] ^ 8'h80, dma_addr_i[7:0]};
          last_q     <= {dma_addr_i[7:0] ^ 8'h80, dma_addr_i[7:0]};
          wait_q     <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

// ### acso_period_timer.sv
// Sampling period timer counting system clock ticks
`timescale 1ns/1ns
module acso_period_timer
  import acso_pkg::*;
(
  // Clock and reset
  input wire logic   clk_i,
  input wire logic   rst_i,
  // Channel side
  acso_tick_if.timer tif
);

  logic [ACSO_PW-1:0] cnt_q;
  logic [ACSO_PW-1:0] cnt_d;

  // A period of zero behaves as one so the channel can never stall forever
  assign tif.tick = tif.run && (cnt_q <= ACSO_PW'(1)); // RQ10

  // Next count: reload on expiry or while stopped
  always_comb begin
    cnt_d = cnt_q;
    if (!tif.run || tif.tick) begin
      cnt_d = tif.period; // RQ10
    end else begin
      cnt_d = cnt_q - ACSO_PW'(1);
    end
  end

  // Count register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= ACSO_PER_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  chk_tick_reload: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    tif.tick |=> (cnt_q == $past(tif.period)))
    else $error("timer did not reload the period after expiry");

  // A reload longer than one tick must leave at least one quiet cycle after each tick
  chk_tick_gap: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    (tif.tick && tif.period > ACSO_PW'(1)) |=> !tif.tick)
    else $error("sampling tick spacing differs from the period");

endmodule

// ### acso_pkg.sv
// Shared constants and types for the audio channel sample output block
package acso_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] ACSO_CTRL_OFS  = 8'h00;
  localparam logic [7:0] ACSO_LOC_OFS   = 8'h04;
  localparam logic [7:0] ACSO_LEN_OFS   = 8'h08;
  localparam logic [7:0] ACSO_PER_OFS   = 8'h0c;
  localparam logic [7:0] ACSO_VOL_OFS   = 8'h10;
  localparam logic [7:0] ACSO_DAT_OFS   = 8'h14;
  localparam logic [7:0] ACSO_STAT_OFS  = 8'h18;
  localparam logic [7:0] ACSO_MASK_OFS  = 8'h1c;
  localparam logic [7:0] ACSO_STATE_OFS = 8'h20;

  // Control field positions
  localparam int ACSO_CTRL_DMA  = 0;
  localparam int ACSO_CTRL_FILT = 1;

  // Status and mask field positions
  localparam int ACSO_EV_ADDR   = 0;
  localparam int ACSO_EV_WORD   = 1;
  localparam int ACSO_EV_STARVE = 2;
  localparam int ACSO_NEV       = 3;

  // Widths
  localparam int ACSO_PW = 16;

  // Values after reset
  localparam logic [1:0]  ACSO_CTRL_RST = 2'h0;
  localparam logic [15:0] ACSO_LEN_RST  = 16'h0001;
  localparam logic [15:0] ACSO_PER_RST  = 16'h007c;
  localparam logic [6:0]  ACSO_VOL_RST  = 7'h00;

  // Sampling intervals without data before the starvation event is raised
  localparam logic [1:0] ACSO_STARVE_TICKS = 2'h2;

  // Output byte sequencer
  typedef enum logic {PS_EMPTY, PS_LOW_NEXT} acso_play_type;

endpackage

// ### acso_tick_if.sv
// Link between the channel and its sampling period timer
`timescale 1ns/1ns
interface acso_tick_if;
  import acso_pkg::*;
  logic [ACSO_PW-1:0] period;
  logic               run;
  logic               tick;
  modport timer (input period, input run, output tick);
  modport chan  (output period, output run, input tick);
endinterface

// ### tb_top.sv
// Self-checking bench for the audio channel sample output block
`timescale 1ns/1ns
module tb_top;
  import acso_pkg::*;
  logic              clk, rst, psel, pen, pwr, ack, req, pready, perr, led, irq, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [23:0]       daddr;
  logic [15:0]       ddata, level;
  logic signed [7:0] smp;
  logic [6:0]        vol;
  logic [23:0]       fetched[$];
  int                mismatches, n_checks, cycles, n;

  acso_channel i_acso_channel (
    .SYS_CLK_I(clk), .SYS_RST_I(rst), .APB_PSEL_I(psel), .APB_PENABLE_I(pen),
    .APB_PWRITE_I(pwr), .APB_PADDR_I(paddr), .APB_PWDATA_I(pwdata), .APB_PRDATA_O(prdata),
    .APB_PREADY_O(pready), .APB_PSLVERR_O(perr), .DMA_REQ_O(req), .DMA_ADDR_O(daddr),
    .DMA_ACK_I(ack), .DMA_DATA_I(ddata), .DAC_SAMPLE_O(smp), .DAC_VOLUME_O(vol),
    .DAC_LEVEL_O(level), .FILTER_LED_O(led), .IRQ_O(irq));

  // Slow answers: three idle cycles before each fetched word
  acso_mem_model i_acso_mem_model (
    .clk_i(clk), .rst_i(rst), .dma_req_i(req), .dma_addr_i(daddr), .lat_i(4'h3),
    .dma_ack_o(ack), .dma_data_o(ddata));

  // Clock, 40 ns period
  always #20 clk = ~clk;

  // Log fetched addresses and cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (req === 1'b1 && ack === 1'b1) fetched.push_back(daddr);
    if (cycles == 6000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude;
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // Wait for a sample value, return the cycles it took
  task automatic wait_smp(input logic [7:0] v, output int cnt);
    cnt = 0;
    while (smp !== v && cnt < 400) begin
      @(negedge clk);
      cnt++;
    end
    chk({24'h0, smp}, {24'h0, v});
  endtask

  // Reset values and an unmapped address
  task automatic t_reset;
    logic [7:0]  ofs[9];
    logic [31:0] exp[9];
    ofs = '{ACSO_CTRL_OFS, ACSO_LOC_OFS, ACSO_LEN_OFS, ACSO_PER_OFS, ACSO_VOL_OFS,
            ACSO_DAT_OFS, ACSO_STAT_OFS, ACSO_MASK_OFS, ACSO_STATE_OFS};
    exp = '{32'h0, 32'h0, 32'h1, 32'h7c, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, exp[i]);
      chk({31'h0, err}, 32'h0);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  // Direct writes: pacing, volume, word-sent and starvation events
  task automatic t_direct;
    apb(1'b1, ACSO_PER_OFS, 32'h8);
    apb(1'b1, ACSO_VOL_OFS, 32'h40);
    apb(1'b1, ACSO_MASK_OFS, 32'h6);
    apb(1'b1, ACSO_DAT_OFS, 32'h7f80);
    wait_smp(8'h7f, n);
    wait_smp(8'h80, n);
    chk(n, 8);
    @(negedge clk);
    chk({16'h0, level}, 32'he000);
    chk({25'h0, vol}, 32'h40);
    repeat (40) @(negedge clk);
    chk({24'h0, smp}, 32'h80);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, ACSO_STAT_OFS, 32'h0);
    chk(rd, 32'h6);
    apb(1'b0, ACSO_STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  // Filter bypass bit drives the shared LED output
  task automatic t_filter;
    apb(1'b1, ACSO_CTRL_OFS, 32'h2);
    @(negedge clk);
    chk({31'h0, led}, 32'h1);
    apb(1'b0, ACSO_CTRL_OFS, 32'h0);
    chk(rd, 32'h2);
  endtask

  // Fetch mode: start event, byte order, reload of a single buffer
  task automatic t_dma;
    apb(1'b1, ACSO_LOC_OFS, 32'h40);
    apb(1'b1, ACSO_LEN_OFS, 32'h2);
    apb(1'b1, ACSO_MASK_OFS, 32'h1);
    apb(1'b1, ACSO_CTRL_OFS, 32'h3);
    n = 0;
    while (irq !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, ACSO_STAT_OFS, 32'h0);
    chk(rd, 32'h1);
    // A direct word while fetching is refused; the fetched bytes below must still play
    apb(1'b1, ACSO_DAT_OFS, 32'h1234);
    wait_smp(8'hc0, n);
    @(negedge clk);
    chk({16'h0, level}, 32'hf000);
    wait_smp(8'h40, n);
    wait_smp(8'hc2, n);
    wait_smp(8'h42, n);
    wait_smp(8'hc0, n);
    chk(fetched[0], 24'h40);
    chk(fetched[1], 24'h42);
    chk(fetched[2], 24'h40);
    apb(1'b0, ACSO_STAT_OFS, 32'h0);
    chk(rd, 32'h1);
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_direct();
    t_filter();
    t_dma();
    conclude();
  end
endmodule
